// file: core/front_panel_setting_controller.sv
`timescale 1ns/1ps
module front_panel_setting_controller
	import panel_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NKEYS-1:0] keys_raw,
	input wire logic noise_display,
	output setting_s setting,
	output logic signed [15:0] offset_applied,
	output logic signed [15:0] phase_setting,
	output logic signed [19:0] output_value,
	output logic expand_on_lamp,
	output logic expand_off_lamp,
	output logic rel_lamp,
	output logic offset_lamp,
	output logic [2:0] tc2_lamps,
	output logic [1:0] noise_bandwidth_select,
	output logic noise_restart,
	output logic banner,
	output logic error_lamp,
	output logic remote
);
	////////////////////////////////////////////////////////////////////
	// Key synchronisers and tick divider
	logic [NKEYS-1:0] k1_q, k2_q, kp_q;
	logic [19:0] div_q;
	logic tick;
	assign tick = div_q == 20'(TICK_CYC - 1);
	wire [NKEYS-1:0] press = k2_q & ~kp_q;
	wire [NKEYS-1:0] held = k2_q;
	// Synchroniser runs through reset so a held key is seen at boot
	always_ff @(posedge pclk)
	begin
		k1_q <= keys_raw;
		k2_q <= k1_q;
	end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			kp_q <= '0;
			div_q <= '0;
		end
		else
		begin
			kp_q <= k2_q;
			div_q <= tick ? '0 : div_q + 20'd1;
		end
	////////////////////////////////////////////////////////////////////
	// APB registers
	logic signed [15:0] x_q, ofs_q, ph_q;
	logic [1:0] rem_q;
	logic [31:0] rd_d;
	wire wr = psel & penable & pwrite;
	wire rd_hit = paddr == OFF_CTRL || paddr == OFF_XVAL || paddr == OFF_STAT ||
		paddr == OFF_OFFSET || paddr == OFF_PHAS || paddr == OFF_OUTV || paddr == OFF_REMC;
	always_comb
	begin
		case (paddr)
			OFF_CTRL: rd_d = {17'h0, setting};
			OFF_XVAL: rd_d = {16'h0, x_q};
			OFF_STAT: rd_d = {26'h0, banner, error_lamp, rel_lamp, offset_lamp, remote, 1'b0};
			OFF_OFFSET: rd_d = {16'h0, ofs_q};
			OFF_PHAS: rd_d = {16'h0, ph_q};
			OFF_OUTV: rd_d = {12'h0, output_value};
			OFF_REMC: rd_d = {30'h0, rem_q};
			default: rd_d = 32'h0;
		endcase
	end
	// rem_q: bit0 remote, bit1 lockout
	////////////////////////////////////////////////////////////////////
	// Settings state
	setting_s s_q;
	logic [3:0] ofs_acc_q, ph_acc_q;
	logic [6:0] tc_rep_q;
	logic [8:0] ofs_hold_q, ph_hold_q;
	logic [8:0] ban_q, err_q;
	logic [5:0] blink_q;
	logic rel_blink_q, ofs_blink_q, nrst_q, boot_q;
	wire en = !rem_q[0];
	wire signed [15:0] ofs_step = (16'sd1 <<< ofs_acc_q) > OFS_STEP_MAX ? OFS_STEP_MAX :
		(16'sd1 <<< ofs_acc_q);
	wire signed [15:0] ph_step = (16'sd1 <<< ph_acc_q) > PH_STEP_MAX ? PH_STEP_MAX :
		(16'sd1 <<< ph_acc_q);
	wire ofs_hit = en & s_q.ofs_on & (press[K_OFS_UP] | press[K_OFS_DN] |
		(tick & ofs_hold_q == 9'(ACCEL_TICKS) & (held[K_OFS_UP] | held[K_OFS_DN])));
	wire signed [16:0] ofs_sum = held[K_OFS_UP] ? 17'(ofs_q) + 17'(ofs_step) :
		17'(ofs_q) - 17'(ofs_step);
	wire ofs_over = ofs_sum > 17'(OFS_LIMIT) || ofs_sum < -17'(OFS_LIMIT);
	wire ph_hit = en & (press[K_PH_UP] | press[K_PH_DN] |
		(tick & ph_hold_q == 9'(ACCEL_TICKS) & (held[K_PH_UP] | held[K_PH_DN])));
	wire signed [16:0] ph_fine = held[K_PH_UP] ? 17'(ph_q) + 17'(ph_step) :
		17'(ph_q) - 17'(ph_step);
	wire signed [16:0] ph_quad = press[K_Q_UP] ? 17'(ph_q) + 17'(PH_QUAD) :
		17'(ph_q) - 17'(PH_QUAD);
	wire signed [16:0] ph_raw = ph_hit ? ph_fine : ph_quad;
	wire signed [15:0] ph_wrap = ph_raw > 17'(PH_HALF) ? 16'(ph_raw - 17'(2 * PH_HALF)) :
		ph_raw < -17'(PH_HALF) ? 16'(ph_raw + 17'(2 * PH_HALF)) : 16'(ph_raw);
	wire x_big = x_q > OFS_LIMIT || x_q < -OFS_LIMIT;
	wire tc_rep = tick & tc_rep_q == 7'(REPEAT_TICKS);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			s_q <= '0;
			ofs_q <= '0;
			ph_q <= '0;
			x_q <= '0;
			rem_q <= '0;
			ofs_acc_q <= '0;
			ph_acc_q <= '0;
			ofs_hold_q <= '0;
			ph_hold_q <= '0;
			tc_rep_q <= '0;
			rel_blink_q <= 1'b0;
			ofs_blink_q <= 1'b0;
			nrst_q <= 1'b0;
			boot_q <= 1'b1;
			ban_q <= '0;
			err_q <= '0;
			blink_q <= '0;
		end
		else
		begin
			nrst_q <= 1'b0;
			if (wr && paddr == OFF_XVAL)
				x_q <= pwdata[15:0];
			if (wr && paddr == OFF_REMC)
				rem_q <= pwdata[1:0];
			else if (press[K_DISP_UP] && rem_q == 2'b01)
				rem_q <= 2'b00;
			if (tick)
				blink_q <= blink_q == 6'(2 * BLINK_TICKS - 1) ? '0 : blink_q + 6'd1;
			if (tick && ban_q != 0)
				ban_q <= ban_q - 9'd1;
			if (tick && err_q != 0)
				err_q <= err_q - 9'd1;
			if (boot_q)
			begin
				boot_q <= 1'b0;
				ban_q <= 9'(BANNER_TICKS);
				if (k2_q[K_REL])
				begin
					s_q <= '0;
					s_q.tc1 <= TC1_DEFAULT;
					ofs_q <= '0;
					ph_q <= '0;
					err_q <= 9'(ERR_TICKS);
				end
			end
			else if (en)
			begin
				if (press[K_EXPAND])
					s_q.expand <= ~s_q.expand;
				if (press[K_REL] && !s_q.rel_on)
				begin
					s_q.rel_on <= 1'b1;
					s_q.ofs_on <= 1'b0;
					ofs_blink_q <= 1'b0;
					rel_blink_q <= x_big;
					ofs_q <= x_q > OFS_LIMIT ? -OFS_LIMIT : x_q < -OFS_LIMIT ? OFS_LIMIT : -x_q;
				end
				else if (press[K_REL])
				begin
					s_q.rel_on <= 1'b0;
					rel_blink_q <= 1'b0;
				end
				if (press[K_OFS_TOG])
				begin
					s_q.ofs_on <= ~s_q.ofs_on;
					ofs_blink_q <= 1'b0;
					if (!s_q.ofs_on)
					begin
						s_q.rel_on <= 1'b0;
						rel_blink_q <= 1'b0;
					end
				end
				else if (ofs_hit)
				begin
					ofs_blink_q <= ofs_over;
					ofs_q <= ofs_over ? (held[K_OFS_UP] ? OFS_LIMIT : -OFS_LIMIT) : 16'(ofs_sum);
				end
				if (!(held[K_OFS_UP] | held[K_OFS_DN]))
				begin
					ofs_hold_q <= '0;
					ofs_acc_q <= '0;
				end
				else if (tick)
				begin
					ofs_hold_q <= ofs_hold_q == 9'(ACCEL_TICKS) ? '0 : ofs_hold_q + 9'd1;
					if (ofs_hit && ofs_acc_q != 4'd9)
						ofs_acc_q <= ofs_acc_q + 4'd1;
				end
				if (!(held[K_TC1_UP] | held[K_TC1_DN]))
					tc_rep_q <= '0;
				else if (tick)
					tc_rep_q <= tc_rep ? '0 : tc_rep_q + 7'd1;
				if (!noise_display && (press[K_TC1_UP] || (tc_rep && held[K_TC1_UP])) &&
					s_q.tc1 != TC1_MAX)
					s_q.tc1 <= s_q.tc1 + 5'd1;
				else if (!noise_display && (press[K_TC1_DN] || (tc_rep && held[K_TC1_DN])) &&
					s_q.tc1 != 5'd0)
					s_q.tc1 <= s_q.tc1 - 5'd1;
				if (noise_display)
				begin
					if (press[K_TC2_UP])
					begin
						s_q.noise_bw10 <= 1'b0;
						nrst_q <= !s_q.noise_bw10;
					end
					else if (press[K_TC2_DN])
					begin
						s_q.noise_bw10 <= 1'b1;
						nrst_q <= s_q.noise_bw10;
					end
				end
				else if (press[K_TC2_UP] && s_q.tc2 != TC2_MAX)
					s_q.tc2 <= s_q.tc2 + 2'd1;
				else if (press[K_TC2_DN] && s_q.tc2 != TC2_NONE)
					s_q.tc2 <= s_q.tc2 - 2'd1;
				if (press[K_TRIG])
					s_q.trig <= s_q.trig == TRIG_NEG ? TRIG_SYM : trig_e'(s_q.trig + 2'd1);
				if (press[K_HARM])
					s_q.harm2 <= ~s_q.harm2;
				if (press[K_PH_UP] | press[K_PH_DN] | press[K_Q_UP] | press[K_Q_DN])
					s_q.ref_show_phase <= 1'b1;
				else if (press[K_SELECT])
					s_q.ref_show_phase <= ~s_q.ref_show_phase;
				if (held[K_Q_UP] && held[K_Q_DN])
					ph_q <= '0;
				else if (ph_hit || press[K_Q_UP] || press[K_Q_DN])
					ph_q <= ph_wrap;
				if (!(held[K_PH_UP] | held[K_PH_DN]))
				begin
					ph_hold_q <= '0;
					ph_acc_q <= '0;
				end
				else if (tick)
				begin
					ph_hold_q <= ph_hold_q == 9'(ACCEL_TICKS) ? '0 : ph_hold_q + 9'd1;
					if (ph_hit && ph_acc_q != 4'd9)
						ph_acc_q <= ph_acc_q + 4'd1;
				end
			end
		end
	////////////////////////////////////////////////////////////////////
	// Registered outputs
	wire blink_on = blink_q < 6'(BLINK_TICKS);
	wire signed [15:0] ofs_app = (s_q.rel_on | s_q.ofs_on) ? ofs_q : 16'sd0;
	wire signed [16:0] osum = 17'(x_q) + 17'(ofs_app);
	wire signed [19:0] vout = s_q.expand ? 20'(osum) * 20'sd100 : 20'(osum) * 20'sd10;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			setting <= '0;
			offset_applied <= '0;
			phase_setting <= '0;
			output_value <= '0;
			expand_on_lamp <= 1'b0;
			expand_off_lamp <= 1'b1;
			rel_lamp <= 1'b0;
			offset_lamp <= 1'b0;
			tc2_lamps <= '0;
			noise_bandwidth_select <= '0;
			noise_restart <= 1'b0;
			banner <= 1'b0;
			error_lamp <= 1'b0;
			remote <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~rd_hit & ~(pwrite & paddr == OFF_KEYS);
			if (psel & ~penable & ~pwrite)
				prdata <= rd_d;
			setting <= s_q;
			offset_applied <= ofs_app;
			phase_setting <= ph_q;
			output_value <= vout;
			expand_on_lamp <= s_q.expand;
			expand_off_lamp <= ~s_q.expand;
			rel_lamp <= s_q.rel_on & (~rel_blink_q | blink_on);
			offset_lamp <= s_q.ofs_on & (~ofs_blink_q | blink_on);
			tc2_lamps <= noise_display ? 3'h0 : 3'(3'h1 << s_q.tc2);
			noise_bandwidth_select <= noise_display ? {s_q.noise_bw10, ~s_q.noise_bw10} : 2'h0;
			noise_restart <= nrst_q;
			banner <= ban_q != 0;
			error_lamp <= err_q != 0;
			remote <= rem_q[0];
		end
	////////////////////////////////////////////////////////////////////
	// Assertions
	property p_expand_lamps;
		@(posedge pclk) disable iff (!presetn)
		expand_on_lamp != expand_off_lamp;
	endproperty
	a_expand_lamps: assert property (p_expand_lamps) else $error("expand lamps disagree");
	property p_rel_load;
		@(posedge pclk) disable iff (!presetn)
		en && !boot_q && press[K_REL] && !s_q.rel_on && !x_big |=> ofs_q == -$past(x_q);
	endproperty
	a_rel_load: assert property (p_rel_load) else $error("rel did not load minus x");
	property p_rel_clamp;
		@(posedge pclk) disable iff (!presetn)
		en && !boot_q && press[K_REL] && !s_q.rel_on && x_big |=> rel_blink_q;
	endproperty
	a_rel_clamp: assert property (p_rel_clamp) else $error("rel clamp not flagged");
	property p_ofs_limit;
		@(posedge pclk) disable iff (!presetn)
		ofs_q <= OFS_LIMIT && ofs_q >= -OFS_LIMIT;
	endproperty
	a_ofs_limit: assert property (p_ofs_limit) else $error("offset beyond limit");
	property p_ofs_off_zero;
		@(posedge pclk) disable iff (!presetn)
		!s_q.ofs_on && !s_q.rel_on |=> offset_applied == 16'sd0;
	endproperty
	a_ofs_off_zero: assert property (p_ofs_off_zero) else $error("applied offset not zero");
	property p_phase_range;
		@(posedge pclk) disable iff (!presetn)
		ph_q <= PH_HALF && ph_q >= -PH_HALF;
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("phase out of range");
	property p_lockout;
		@(posedge pclk) disable iff (!presetn)
		rem_q == 2'b11 && !(wr && paddr == OFF_REMC) |=> rem_q == 2'b11;
	endproperty
	a_lockout: assert property (p_lockout) else $error("lockout left without command");
	property p_exclusive;
		@(posedge pclk) disable iff (!presetn)
		!(s_q.rel_on && s_q.ofs_on);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("rel and offset both on");
endmodule // front_panel_setting_controller

// file: core/panel_pkg.sv
package panel_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_KEYS = 8'h04;
	localparam logic [7:0] OFF_XVAL = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_OFFSET = 8'h10;
	localparam logic [7:0] OFF_PHAS = 8'h14;
	localparam logic [7:0] OFF_OUTV = 8'h18;
	localparam logic [7:0] OFF_REMC = 8'h1c;
	// Key bit positions in the key register
	localparam int K_EXPAND = 0;
	localparam int K_REL = 1;
	localparam int K_OFS_TOG = 2;
	localparam int K_OFS_UP = 3;
	localparam int K_OFS_DN = 4;
	localparam int K_TC1_UP = 5;
	localparam int K_TC1_DN = 6;
	localparam int K_TC2_UP = 7;
	localparam int K_TC2_DN = 8;
	localparam int K_TRIG = 9;
	localparam int K_HARM = 10;
	localparam int K_SELECT = 11;
	localparam int K_PH_UP = 12;
	localparam int K_PH_DN = 13;
	localparam int K_Q_UP = 14;
	localparam int K_Q_DN = 15;
	localparam int K_DISP_UP = 16;
	localparam int NKEYS = 17;
	// Fixed-point scales: offset and x in units of 0.025 % FS, phase in 0.025 degree
	localparam logic signed [15:0] OFS_LIMIT = 16'sd4096;
	localparam logic signed [15:0] OFS_STEP_MAX = 16'sd400;
	localparam logic signed [15:0] PH_HALF = 16'sd7200;
	localparam logic signed [15:0] PH_QUAD = 16'sd3600;
	localparam logic signed [15:0] PH_STEP_MAX = 16'sd400;
	localparam logic [4:0] TC1_MAX = 5'd15;
	localparam logic [4:0] TC1_DEFAULT = 5'd6;
	localparam logic [4:0] SENS_DEFAULT = 5'd23;
	localparam logic [1:0] TC2_NONE = 2'd0;
	localparam logic [1:0] TC2_MAX = 2'd2;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int REPEAT_MS = 500;
	localparam int REPEAT_TICKS = REPEAT_MS / TICK_MS;
	localparam int ACCEL_TICKS = 10;
	localparam int BANNER_MS = 2000;
	localparam int BANNER_TICKS = BANNER_MS / TICK_MS;
	localparam int ERR_MS = 3000;
	localparam int ERR_TICKS = ERR_MS / TICK_MS;
	localparam int BLINK_TICKS = 25;
	typedef enum logic [1:0] {TRIG_SYM, TRIG_POS, TRIG_NEG} trig_e;
	typedef struct packed {
		logic expand;
		logic rel_on;
		logic ofs_on;
		logic harm2;
		logic ref_show_phase;
		logic noise_bw10;
		trig_e trig;
		logic [4:0] tc1;
		logic [1:0] tc2;
	} setting_s;
endpackage

// file: test/key_panel_model.sv
`timescale 1ns/1ps
module key_panel_model
	import panel_pkg::*;
(
	input wire logic pclk,
	input wire logic go,
	input wire logic [NKEYS-1:0] mask,
	input wire logic [NKEYS-1:0] hold,
	output logic [NKEYS-1:0] keys_raw,
	output logic busy
);
	logic [3:0] cnt_q = 4'h0;
	logic [NKEYS-1:0] act_q = '0;
	assign keys_raw = (cnt_q > 4'h6 ? act_q : '0) | hold;
	assign busy = cnt_q != 4'h0;
	always_ff @(posedge pclk)
	begin
		if (go)
		begin
			cnt_q <= 4'hc;
			act_q <= mask;
		end
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule // key_panel_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench
	import panel_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, noise_display = 0, go = 0, busy, seen = 0;
	logic [NKEYS-1:0] keys_raw, mask = '0, hold = '0;
	setting_s setting;
	logic signed [15:0] offset_applied, phase_setting;
	logic signed [19:0] output_value;
	logic expand_on_lamp, expand_off_lamp, rel_lamp, offset_lamp, noise_restart;
	logic banner, error_lamp, remote;
	logic [2:0] tc2_lamps;
	logic [1:0] noise_bandwidth_select;
	int miscompares = 0, comparisons = 0;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) if (noise_restart === 1'b1) seen <= 1'b1;
	front_panel_setting_controller i_front_panel_setting_controller (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.keys_raw(keys_raw), .noise_display(noise_display), .setting(setting),
		.offset_applied(offset_applied), .phase_setting(phase_setting),
		.output_value(output_value), .expand_on_lamp(expand_on_lamp),
		.expand_off_lamp(expand_off_lamp), .rel_lamp(rel_lamp), .offset_lamp(offset_lamp),
		.tc2_lamps(tc2_lamps), .noise_bandwidth_select(noise_bandwidth_select),
		.noise_restart(noise_restart), .banner(banner), .error_lamp(error_lamp),
		.remote(remote));
	key_panel_model i_key_panel_model (.pclk(pclk), .go(go), .mask(mask), .hold(hold),
		.keys_raw(keys_raw), .busy(busy));
	////////////////////////////////////////////////////////////////////////
	task end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
		begin
			miscompares++;
			end_sim();
		end
	endtask
	task press(input logic [NKEYS-1:0] m);
		int i;
		@(posedge pclk);
		go <= 1'b1;
		mask <= m;
		@(posedge pclk);
		go <= 1'b0;
		for (i = 0; i < 40; i++)
		begin
			@(posedge pclk);
			if (busy === 1'b0)
				break;
		end
		if (i == 40)
		begin
			miscompares++;
			end_sim();
		end
		repeat (2) @(posedge pclk);
	endtask
	task k(input int i);
		press(NKEYS'(1) << i);
	endtask
	task do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5) @(posedge pclk);
		hold <= '0;
		repeat (5) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task sc_defaults();
		chk("err", error_lamp, 1);
		chk("banner", banner, 1);
		chk("tc1", setting.tc1, TC1_DEFAULT);
		chk("phase", 32'(phase_setting), 0);
		chk("ofs", 32'(offset_applied), 0);
		noise_display <= 1'b1;
		k(K_TC1_UP);
		chk("tc1 noise", setting.tc1, TC1_DEFAULT);
		chk("tc2 lamps", tc2_lamps, 0);
		noise_display <= 1'b0;
		k(K_TC1_UP);
		chk("tc1 up", setting.tc1, TC1_DEFAULT + 1);
		k(K_TC1_DN);
		k(K_TC1_DN);
		chk("tc1 dn", setting.tc1, TC1_DEFAULT - 1);
	endtask
	task sc_offset();
		apb(1, OFF_XVAL, 32'd100);
		k(K_REL);
		chk("rel", setting.rel_on, 1);
		chk("ofs", 32'(offset_applied), -100);
		chk("rel lamp", rel_lamp, 1);
		chk("out", 32'(output_value), 0);
		k(K_REL);
		chk("ofs off", 32'(offset_applied), 0);
		k(K_OFS_TOG);
		chk("ofs man", 32'(offset_applied), -100);
		chk("ofs lamp", offset_lamp, 1);
		k(K_OFS_UP);
		chk("ofs step", 32'(offset_applied), -99);
		chk("out1", 32'(output_value), 10);
		k(K_EXPAND);
		chk("exp", setting.expand, 1);
		chk("lamps", {expand_on_lamp, expand_off_lamp}, 2'b10);
		chk("out10", 32'(output_value), 100);
		k(K_EXPAND);
		chk("lamps2", {expand_on_lamp, expand_off_lamp}, 2'b01);
		k(K_OFS_TOG);
		chk("tog off", 32'(offset_applied), 0);
		chk("ofs lamp off", offset_lamp, 0);
		k(K_OFS_TOG);
		chk("tog on", 32'(offset_applied), -99);
		apb(1, OFF_XVAL, 32'd50);
		k(K_REL);
		chk("man off", {setting.ofs_on, setting.rel_on}, 2'b01);
		chk("ofs50", 32'(offset_applied), -50);
		apb(0, OFF_OFFSET, 0);
		chk("ofs rd", rd[15:0], 16'hffce);
		k(K_OFS_TOG);
		chk("rel off", {setting.ofs_on, setting.rel_on}, 2'b10);
		chk("kept", 32'(offset_applied), -50);
		apb(1, OFF_XVAL, 32'd5000);
		k(K_REL);
		chk("clamp", 32'(offset_applied), -32'(OFS_LIMIT));
		k(K_REL);
	endtask
	task sc_filters();
		chk("tc2 none", tc2_lamps, 3'b001);
		k(K_TC2_UP);
		chk("tc2 1", tc2_lamps, 3'b010);
		k(K_TC2_UP);
		chk("tc2 2", tc2_lamps, 3'b100);
		noise_display <= 1'b1;
		seen = 1'b0;
		k(K_TC2_UP);
		chk("restart1", seen, 1);
		chk("bw1", noise_bandwidth_select, 2'b01);
		k(K_TC2_DN);
		chk("bw10", noise_bandwidth_select, 2'b10);
		seen = 1'b0;
		k(K_TC2_DN);
		chk("restart10", seen, 1);
		noise_display <= 1'b0;
	endtask
	task sc_ref();
		trig_e t[3] = '{TRIG_POS, TRIG_NEG, TRIG_SYM};
		for (int i = 0; i < 3; i++)
		begin
			k(K_TRIG);
			chk("trig", setting.trig, t[i]);
		end
		k(K_HARM);
		chk("harm", setting.harm2, 1);
		k(K_HARM);
		chk("harm", setting.harm2, 0);
		k(K_SELECT);
		chk("sel", setting.ref_show_phase, 1);
		k(K_SELECT);
		k(K_PH_UP);
		chk("show ph", setting.ref_show_phase, 1);
		chk("fine", 32'(phase_setting), 1);
		k(K_Q_UP);
		chk("q up", 32'(phase_setting), 3601);
		k(K_Q_UP);
		chk("wrap", 32'(phase_setting), -7199);
		press((NKEYS'(1) << K_Q_UP) | (NKEYS'(1) << K_Q_DN));
		chk("zero", 32'(phase_setting), 0);
		k(K_PH_DN);
		chk("fine dn", 32'(phase_setting), -1);
	endtask
	task sc_remote();
		apb(1, OFF_REMC, 32'h1);
		repeat (2) @(posedge pclk);
		chk("rem", remote, 1);
		k(K_EXPAND);
		chk("ignored", setting.expand, 0);
		k(K_DISP_UP);
		chk("local", remote, 0);
		apb(1, OFF_REMC, 32'h3);
		k(K_DISP_UP);
		chk("locked", remote, 1);
		apb(1, OFF_REMC, 32'h0);
		repeat (2) @(posedge pclk);
		chk("cmd local", remote, 0);
		apb(0, OFF_KEYS, 0);
		chk("keys rd", rd, 0);
		chk("keys err", er, 1);
		apb(0, 8'h20, 0);
		chk("unmapped", er, 1);
	endtask
	initial
	begin
		hold <= NKEYS'(1) << K_REL;
		do_reset();
		sc_defaults();
		do_reset();
		sc_offset();
		sc_filters();
		sc_ref();
		sc_remote();
		end_sim();
	end
endmodule // testbench
